// >>> verilog/dbg_serial_cmd_engine.sv
// serial debug command engine: command decode, register and memory access
`timescale 1ns/1ps
`default_nettype none
module dbg_serial_cmd_engine #(
  parameter int num_regs = 8
) (
  input wire logic clock,
  input wire logic reset,
  // one 16-bit serial exchange completes when word_valid pulses
  input wire logic word_valid,
  input wire logic [15:0] word_in,
  output logic [16:0] resp_q,
  output logic busy_q,
  // processor register access, only while halted
  input wire logic core_halted,
  input wire logic [dbg_cmd_pkg::attr_width-1:0] address_attribute_register,
  output logic reg_we_q,
  output logic reg_addr_sel_q,
  output logic [2:0] reg_num_q,
  output logic [31:0] reg_wdata_q,
  input wire logic [31:0] reg_rdata,
  // memory bus cycle
  output logic mem_req_q,
  output dbg_cmd_pkg::mem_req_s mem_q,
  input wire logic mem_done,
  input wire logic bus_error_termination,
  input wire logic [31:0] mem_rdata
);

  typedef enum logic [2:0] {
    st_cmd, st_ext1, st_ext2, st_ext3, st_ext4, st_mem, st_res_hi
  } state_e;

  state_e state_q, state_d;
  dbg_cmd_pkg::cmd_s cmd_dec;
  dbg_cmd_pkg::cmd_s cmd_q;
  logic [31:0] addr_q, data_q;
  logic [16:0] resp_d, pend_q;
  logic [3:0] gap_q;
  logic [31:0] addr_aligned;

  dbg_cmd_decode u_decode (
    .cmd_word(word_in),
    .cmd(cmd_dec)
  );

  // a read starts while its low address half is still on word_in
  wire [31:0] addr_live = (state_q == st_ext2) ? {addr_q[31:16], word_in} : addr_q;
  dbg_addr_align u_align (
    .addr_in(addr_live),
    .size(cmd_q.size),
    .addr_out(addr_aligned)
  );

  // number of data extension words for the current command
  function automatic logic two_words(input logic [1:0] size);
    two_words = (size == dbg_cmd_pkg::size_long);
  endfunction : two_words

  // a transfer counts only when spaced from the last one
  wire take = word_valid && (gap_q == 4'h0);
  wire halted_ok = core_halted;
  wire is_wr_mem = cmd_q.is_mem && !cmd_q.dir_read;
  wire is_rd_mem = cmd_q.is_mem && cmd_q.dir_read;
  wire is_reg = cmd_q.legal && !cmd_q.is_mem && (cmd_q.size == dbg_cmd_pkg::size_long);
  wire new_is_nop = cmd_dec.legal && (word_in == 16'h0000);

  // state and response sequencing
  always_comb begin
    state_d = state_q;
    resp_d = resp_q;
    if (state_q == st_mem) begin
      if (take) resp_d = dbg_cmd_pkg::resp_not_ready;
      // only a good long read has a high result word ahead of the command
      if (mem_done) begin
        state_d = (is_rd_mem && two_words(cmd_q.size) && !bus_error_termination) ?
          st_res_hi : st_cmd;
      end
    end else if (take) begin
      case (state_q)
        st_cmd: begin
          resp_d = pend_q;
          state_d = (cmd_dec.legal && !new_is_nop) ? st_ext1 : st_cmd;
          if (!cmd_dec.legal) state_d = st_ext1;
        end
        st_ext1: begin
          resp_d = cmd_q.legal ? dbg_cmd_pkg::resp_not_ready : dbg_cmd_pkg::resp_illegal;
          if (!cmd_q.legal) state_d = st_cmd;
          else if (is_reg && cmd_q.dir_read) begin
            state_d = halted_ok ? st_res_hi : st_cmd;
          end else state_d = st_ext2;
        end
        st_ext2: begin
          resp_d = dbg_cmd_pkg::resp_not_ready;
          if (is_rd_mem) state_d = st_mem;
          else if (is_reg) state_d = st_cmd;
          else state_d = st_ext3;
        end
        st_ext3: begin
          resp_d = dbg_cmd_pkg::resp_not_ready;
          state_d = two_words(cmd_q.size) ? st_ext4 : st_mem;
        end
        st_ext4: begin
          resp_d = dbg_cmd_pkg::resp_not_ready;
          state_d = st_mem;
        end
        st_res_hi: begin
          resp_d = {1'b0, data_q[31:16]};
          // the word coming in with the low half is the next opcode
          state_d = st_cmd;
        end
        default: begin
          state_d = st_cmd;
        end
      endcase
    end
  end

  // result of a finished memory cycle
  wire [16:0] mem_rd_resp = bus_error_termination ? dbg_cmd_pkg::resp_bus_error :
    {1'b0, 16'h0000};
  wire [31:0] rd_data_sel = (cmd_q.size == dbg_cmd_pkg::size_byte) ? {24'h0, mem_rdata[7:0]} :
    (cmd_q.size == dbg_cmd_pkg::size_word) ? {16'h0, mem_rdata[15:0]} : mem_rdata;

  // state, gap counter and output response
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q <= st_cmd;
      resp_q <= dbg_cmd_pkg::resp_complete;
      gap_q <= 4'h0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      resp_q <= resp_d;
      busy_q <= (state_d == st_mem);
      if (take) gap_q <= 4'(dbg_cmd_pkg::idle_gap_cycles - 1);
      else if (gap_q != 4'h0) gap_q <= gap_q - 4'h1;
    end
  end

  // command capture, extension words and pending result
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cmd_q <= '0;
      addr_q <= 32'h0;
      data_q <= 32'h0;
      pend_q <= dbg_cmd_pkg::resp_complete;
    end else if (state_q == st_mem && mem_done) begin
      if (bus_error_termination) begin
        data_q <= {15'h0, 1'b1, 16'h0001};
        pend_q <= is_wr_mem ? dbg_cmd_pkg::resp_bus_error : dbg_cmd_pkg::resp_bus_error;
      end else begin
        data_q <= rd_data_sel;
        pend_q <= is_wr_mem ? dbg_cmd_pkg::resp_complete :
          {mem_rd_resp[16], two_words(cmd_q.size) ? rd_data_sel[15:0] : rd_data_sel[15:0]};
      end
    end else if (take) begin
      case (state_q)
        st_cmd: begin
          cmd_q <= cmd_dec;
          // an illegal word is flagged on its own next transfer, so nothing stays due
          pend_q <= dbg_cmd_pkg::resp_complete;
        end
        st_ext1: begin
          // a register read must not see its upper half replaced by the idle word
          if (is_reg && cmd_q.dir_read) begin
            data_q <= reg_rdata;
            pend_q <= halted_ok ? {1'b0, reg_rdata[15:0]} : dbg_cmd_pkg::resp_bus_error;
          end else begin
            addr_q[31:16] <= word_in;
            data_q[31:16] <= word_in;
          end
        end
        st_ext2: begin
          addr_q[15:0] <= word_in;
          data_q[15:0] <= word_in;
          pend_q <= (is_reg && !halted_ok) ? dbg_cmd_pkg::resp_bus_error :
            dbg_cmd_pkg::resp_complete;
        end
        st_ext3: begin
          data_q <= two_words(cmd_q.size) ? {word_in, 16'h0} : {16'h0, word_in};
        end
        st_ext4: data_q[15:0] <= word_in;
        default: begin
        end
      endcase
    end
  end

  // register write strobe, one cycle after its second data word
  wire reg_wr_go = take && state_q == st_ext2 && is_reg && !cmd_q.dir_read && halted_ok;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      reg_we_q <= 1'b0;
      reg_addr_sel_q <= 1'b0;
      reg_num_q <= 3'h0;
      reg_wdata_q <= 32'h0;
    end else begin
      reg_we_q <= reg_wr_go;
      reg_addr_sel_q <= (state_q == st_cmd) ? cmd_dec.addr_reg : cmd_q.addr_reg;
      reg_num_q <= (state_q == st_cmd) ? cmd_dec.reg_num : cmd_q.reg_num;
      if (reg_wr_go) reg_wdata_q <= {data_q[31:16], word_in};
    end
  end

  // memory request held until the bus answers
  wire mem_go = state_q != st_mem && state_d == st_mem;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mem_req_q <= 1'b0;
      mem_q <= '0;
    end else begin
      if (mem_go) begin
        mem_req_q <= 1'b1;
        mem_q.addr <= addr_aligned;
        mem_q.size <= cmd_q.size;
        mem_q.write <= !cmd_q.dir_read;
        mem_q.attr <= address_attribute_register;
        // the last data word is still on word_in when the write starts
        mem_q.wdata <= (state_q == st_ext4) ? {data_q[31:16], word_in} :
          (state_q == st_ext3) ? {16'h0, word_in} : data_q;
      end else if (mem_done) begin
        mem_req_q <= 1'b0;
      end
    end
  end

  // after a read the low result is sent with the next command
  logic mem_fin_q;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) mem_fin_q <= 1'b0;
    else mem_fin_q <= (state_q == st_mem) && mem_done;
  end

  a_illegal_follow: assert property (@(posedge clock) disable iff (reset)
    (take && state_q == st_ext1 && !cmd_q.legal) |=> resp_q == dbg_cmd_pkg::resp_illegal)
    else $error("illegal command not reported");
  a_busy_not_ready: assert property (@(posedge clock) disable iff (reset)
    (state_q == st_mem && take) |=> resp_q == dbg_cmd_pkg::resp_not_ready)
    else $error("transfer during access not answered not-ready");
  a_third_not_ready: assert property (@(posedge clock) disable iff (reset)
    (take && state_q == st_ext2 && cmd_q.is_mem) |=> resp_q[16] && busy_q == is_rd_mem)
    else $error("third transfer not not-ready");
  a_gap_spacing: assert property (@(posedge clock) disable iff (reset)
    take |=> (gap_q == 4'h7) ##7 (gap_q == 4'h0))
    else $error("transfer spacing wrong");
  a_attr_copy: assert property (@(posedge clock) disable iff (reset)
    mem_go |=> mem_q.attr == $past(address_attribute_register))
    else $error("attribute not used");
  a_align_long: assert property (@(posedge clock) disable iff (reset)
    (mem_req_q && mem_q.size == dbg_cmd_pkg::size_long) |-> mem_q.addr[1:0] == 2'h0)
    else $error("long address not aligned");
  a_reg_halted: assert property (@(posedge clock) disable iff (reset)
    reg_we_q |-> $past(core_halted))
    else $error("register written while running");
  a_resp_top: assert property (@(posedge clock) disable iff (reset)
    (take && state_q == st_res_hi) |=> !resp_q[16])
    else $error("valid result flagged");
  // result hand-over, alignment and halted-core checks
  a_align_word: assert property (@(posedge clock) disable iff (reset)
    (mem_req_q && mem_q.size == dbg_cmd_pkg::size_word) |-> !mem_q.addr[0])
    else $error("word address not aligned");
  a_cmd_prior: assert property (@(posedge clock) disable iff (reset)
    (take && state_q == st_cmd) |=> resp_q == $past(pend_q))
    else $error("prior result not returned with command");
  a_reg_result: assert property (@(posedge clock) disable iff (reset)
    (take && state_q == st_ext1 && is_reg && cmd_q.dir_read && halted_ok) |=>
    (state_q == st_res_hi && data_q == $past(reg_rdata)))
    else $error("register read data not captured");
  a_run_reg_err: assert property (@(posedge clock) disable iff (reset)
    (take && state_q == st_ext2 && is_reg && !halted_ok) |=>
    (pend_q == dbg_cmd_pkg::resp_bus_error && !reg_we_q))
    else $error("register write while running not refused");
  a_mem_err: assert property (@(posedge clock) disable iff (reset)
    (state_q == st_mem && mem_done && bus_error_termination) |=>
    (pend_q == dbg_cmd_pkg::resp_bus_error && state_q == st_cmd))
    else $error("bus error status not kept");
  c_mem_read: cover property (@(posedge clock) disable iff (reset) mem_fin_q && !mem_q.write);
  c_mem_write: cover property (@(posedge clock) disable iff (reset) mem_fin_q && mem_q.write);
  c_reg_write: cover property (@(posedge clock) disable iff (reset) reg_we_q);
  c_reg_read: cover property (@(posedge clock) disable iff (reset)
    take && state_q == st_res_hi && !cmd_q.is_mem);
  c_illegal: cover property (@(posedge clock) disable iff (reset)
    resp_q == dbg_cmd_pkg::resp_illegal);

endmodule : dbg_serial_cmd_engine
`default_nettype wire

// >>> pkg/dbg_cmd_pkg.sv
// shared constants and carrier types for the serial debug command engine
package dbg_cmd_pkg;

  // operand size field encoding
  localparam logic [1:0] size_byte = 2'h0;
  localparam logic [1:0] size_word = 2'h1;
  localparam logic [1:0] size_long = 2'h2;
  localparam logic [1:0] size_rsvd = 2'h3;

  // operation field codes (bits 15:10 of the command word)
  localparam logic [5:0] op_reg_read = 6'h06;
  localparam logic [5:0] op_reg_write = 6'h02;
  localparam logic [5:0] op_mem_read = 6'h07;
  // memory read and write share one code; the direction bit tells them apart
  localparam logic [5:0] op_mem_write = 6'h07;
  localparam logic [5:0] op_nop = 6'h00;

  // field positions inside a command word
  localparam int op_lsb = 10;
  localparam int dir_bit = 7;
  localparam int size_lsb = 4;
  localparam int ad_bit = 3;

  // 17-bit responses
  localparam logic [16:0] resp_complete = 17'h0ffff;
  localparam logic [16:0] resp_not_ready = 17'h10000;
  localparam logic [16:0] resp_bus_error = 17'h10001;
  localparam logic [16:0] resp_illegal = 17'h1ffff;

  // attribute field width and least spacing between transfers
  localparam int attr_width = 5;
  localparam int idle_gap_cycles = 8;

  // decoded command carrier
  typedef struct packed {
    logic legal;
    logic is_mem;
    logic dir_read;
    logic [1:0] size;
    logic addr_reg;
    logic [2:0] reg_num;
  } cmd_s;

  // memory request carrier
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [1:0] size;
    logic write;
    logic [attr_width-1:0] attr;
  } mem_req_s;

endpackage : dbg_cmd_pkg

// >>> verilog/dbg_cmd_decode.sv
// command word decoder
`timescale 1ns/1ps
`default_nettype none
module dbg_cmd_decode (
  input wire logic [15:0] cmd_word,
  output dbg_cmd_pkg::cmd_s cmd
);
  wire [5:0] op = cmd_word[15:10];
  wire dir = cmd_word[dbg_cmd_pkg::dir_bit];
  wire [1:0] size = cmd_word[5:4];
  // register cmds need size long and the direction matching the code
  wire reg_op = (op == dbg_cmd_pkg::op_reg_read && dir) ||
    (op == dbg_cmd_pkg::op_reg_write && !dir);
  wire is_rreg = reg_op && (cmd_word[9:8] == 2'h0) && !cmd_word[6] &&
    (size == dbg_cmd_pkg::size_long);
  // memory cmds reject the reserved size
  wire is_mem = (op == dbg_cmd_pkg::op_mem_read) && (cmd_word[9:8] == 2'h0) &&
    (size != dbg_cmd_pkg::size_rsvd) && (cmd_word[3:0] == 4'h0);
  wire is_nop = (cmd_word == 16'h0000);
  assign cmd.legal = is_rreg || is_mem || is_nop;
  assign cmd.is_mem = is_mem;
  assign cmd.dir_read = dir;
  assign cmd.size = size;
  assign cmd.addr_reg = cmd_word[dbg_cmd_pkg::ad_bit];
  assign cmd.reg_num = cmd_word[2:0];
endmodule : dbg_cmd_decode
`default_nettype wire

// >>> verilog/dbg_addr_align.sv
// forces natural alignment of memory addresses
`timescale 1ns/1ps
`default_nettype none
module dbg_addr_align (
  input wire logic [31:0] addr_in,
  input wire logic [1:0] size,
  output logic [31:0] addr_out
);
  wire [1:0] mask = (size == dbg_cmd_pkg::size_long) ? 2'h0 :
    (size == dbg_cmd_pkg::size_word) ? 2'h2 : 2'h3;
  assign addr_out = {addr_in[31:2], addr_in[1:0] & mask};
endmodule : dbg_addr_align
`default_nettype wire

// >>> sim/dbg_mem_partner.sv
// behavioural memory bus and processor register file beside the engine
`timescale 1ns/1ps
`default_nettype none
module dbg_mem_partner (
  input wire logic clock,
  input wire logic reset,
  input wire logic mem_req_q,
  input wire dbg_cmd_pkg::mem_req_s mem_q,
  input wire logic [7:0] lat,
  input wire logic err,
  output logic mem_done,
  output logic bus_error_termination,
  output logic [31:0] mem_rdata,
  output dbg_cmd_pkg::mem_req_s wr_q,
  input wire logic reg_we_q,
  input wire logic reg_addr_sel_q,
  input wire logic [2:0] reg_num_q,
  input wire logic [31:0] reg_wdata_q,
  output logic [31:0] reg_rdata,
  input wire logic [3:0] peek_idx,
  output logic [31:0] peek
);
  logic [7:0] cnt_q;
  logic fin_q;
  logic [31:0] regs_q [16];
  // slow bus: done after lat cycles, one pulse per request
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cnt_q <= 8'h00;
      fin_q <= 1'b0;
      mem_done <= 1'b0;
      wr_q <= '0;
    end else begin
      mem_done <= 1'b0;
      if (!mem_req_q) begin
        cnt_q <= 8'h00;
        fin_q <= 1'b0;
      end else if (!fin_q && cnt_q == lat) begin
        mem_done <= 1'b1;
        fin_q <= 1'b1;
        wr_q <= mem_q;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end
  assign bus_error_termination = mem_done & err;
  // data only meaningful with done; otherwise a swapped pattern, never stale
  assign mem_rdata = mem_done ? {~mem_q.addr[15:0], mem_q.addr[15:0]}
                              : {mem_q.addr[15:0], ~mem_q.addr[15:0]};
  // address group in the top index bit, number below
  always_ff @(posedge clock) begin
    if (reg_we_q) begin
      regs_q[{reg_addr_sel_q, reg_num_q}] <= reg_wdata_q;
    end
  end
  assign reg_rdata = regs_q[{reg_addr_sel_q, reg_num_q}];
  assign peek = regs_q[peek_idx];
endmodule : dbg_mem_partner
`default_nettype wire

// >>> sim/tb.sv
// self-checking bench for the serial debug command engine
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [16:0] nr = dbg_cmd_pkg::resp_not_ready;
  localparam logic [16:0] il = dbg_cmd_pkg::resp_illegal;
  localparam logic [16:0] ok = dbg_cmd_pkg::resp_complete;
  localparam logic [16:0] be = dbg_cmd_pkg::resp_bus_error;
  logic clock, reset, word_valid, core_halted, err, reg_we_q, reg_addr_sel_q;
  logic [15:0] word_in;
  logic [16:0] resp_q;
  logic busy_q, mem_req_q, mem_done, bus_error_termination;
  logic [4:0] attr;
  logic [7:0] lat;
  logic [2:0] reg_num_q;
  logic [31:0] reg_wdata_q, reg_rdata, mem_rdata, peek;
  logic [3:0] peek_idx;
  dbg_cmd_pkg::mem_req_s mem_q, wr_q;
  int error_cnt = 0;
  int n_tests = 0;
  always #5 clock = ~clock;
  dbg_serial_cmd_engine DUT (.clock(clock), .reset(reset), .word_valid(word_valid),
    .word_in(word_in), .resp_q(resp_q), .busy_q(busy_q), .core_halted(core_halted),
    .address_attribute_register(attr), .reg_we_q(reg_we_q),
    .reg_addr_sel_q(reg_addr_sel_q), .reg_num_q(reg_num_q), .reg_wdata_q(reg_wdata_q),
    .reg_rdata(reg_rdata), .mem_req_q(mem_req_q), .mem_q(mem_q), .mem_done(mem_done),
    .bus_error_termination(bus_error_termination), .mem_rdata(mem_rdata));
  dbg_mem_partner far (.clock(clock), .reset(reset), .mem_req_q(mem_req_q), .mem_q(mem_q),
    .lat(lat), .err(err), .mem_done(mem_done), .bus_error_termination(bus_error_termination),
    .mem_rdata(mem_rdata), .wr_q(wr_q), .reg_we_q(reg_we_q), .reg_addr_sel_q(reg_addr_sel_q),
    .reg_num_q(reg_num_q), .reg_wdata_q(reg_wdata_q), .reg_rdata(reg_rdata),
    .peek_idx(peek_idx), .peek(peek));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  function automatic logic [15:0] cw(logic [5:0] op, logic dir, logic [1:0] sz,
                                     logic ad, logic [2:0] rn);
    return {op, 2'h0, dir, 1'h0, sz, ad, rn};
  endfunction : cw
  // one exchange; the pin goes to the inverse once the word is handed over
  task automatic pulse(input logic [15:0] w);
    word_valid = 1'b1;
    word_in = w;
    @(negedge clock);
    word_valid = 1'b0;
    word_in = ~w;
  endtask : pulse
  // spacing of ten cycles keeps clear of the eight-cycle gap
  task automatic send(input logic [15:0] w);
    pulse(w);
    repeat (9) @(negedge clock);
  endtask : send
  task automatic wait_idle();
    int i;
    i = 0;
    while (busy_q !== 1'b0 && i < 200) begin
      @(negedge clock);
      i++;
    end
    if (i >= 200) begin
      error_cnt++;
      stop_test();
    end
    repeat (2) @(negedge clock);
  endtask : wait_idle
  task automatic reg_rd(input logic ad, input logic [2:0] rn, input logic [31:0] d);
    send(cw(dbg_cmd_pkg::op_reg_read, 1'b1, dbg_cmd_pkg::size_long, ad, rn));
    chk("regr cmd", resp_q, ok);
    send(16'h0000);
    chk("regr wait", resp_q, nr);
    send(16'h0000);
    chk("reg hi", resp_q, {1'b0, d[31:16]});
    send(16'h0000);
    chk("reg lo", resp_q, {1'b0, d[15:0]});
  endtask : reg_rd
  // the final status comes back with the following command word
  task automatic reg_wr(input logic ad, input logic [2:0] rn, input logic [31:0] d,
                        input logic [16:0] r);
    send(cw(dbg_cmd_pkg::op_reg_write, 1'b0, dbg_cmd_pkg::size_long, ad, rn));
    chk("regw cmd", resp_q, ok);
    send(d[31:16]);
    chk("regw hi", resp_q, nr);
    send(d[15:0]);
    chk("regw lo", resp_q, nr);
    send(16'h0000);
    chk("regw end", resp_q, r);
  endtask : reg_wr
  // command, address high then low, optional data high word first
  task automatic mem_op(input logic wr, input logic [1:0] sz, input logic [31:0] a,
                        input logic [31:0] d);
    send(cw(wr ? dbg_cmd_pkg::op_mem_write : dbg_cmd_pkg::op_mem_read, ~wr, sz, 1'b0,
            3'h0));
    chk("mem cmd", resp_q, ok);
    send(a[31:16]);
    chk("addr hi", resp_q, nr);
    send(a[15:0]);
    if (wr && sz == dbg_cmd_pkg::size_long) send(d[31:16]);
    if (wr) send(d[15:0]);
    chk("addr lo", resp_q, nr);
    chk("req addr", mem_q.addr, a & ~{30'h0, sz[1], sz != 2'h0});
    chk("req kind", {mem_q.size, mem_q.write, mem_q.attr}, {sz, wr, attr});
    send(16'h0000);
    chk("in access", resp_q, nr);
    wait_idle();
  endtask : mem_op
  initial begin
    clock = 1'b0;
    reset = 1'b1;
    word_valid = 1'b0;
    word_in = 16'h0000;
    core_halted = 1'b1;
    attr = 5'h15;
    lat = 8'h1e;
    err = 1'b0;
    peek_idx = 4'hb;
    repeat (6) @(negedge clock);
    reset = 1'b0;
    chk("rst resp", resp_q, ok);
    chk("rst req", mem_req_q, 32'h0);
    send(16'hfc00);
    chk("unused op", resp_q, ok);
    send(16'h0000);
    chk("unused rsp", resp_q, il);
    send(cw(dbg_cmd_pkg::op_mem_read, 1'b1, dbg_cmd_pkg::size_rsvd, 1'b0, 3'h0));
    chk("rsvd cmd", resp_q, ok);
    send(16'h0000);
    chk("rsvd size", resp_q, il);
    reg_wr(1'b1, 3'h3, 32'h89abcdef, ok);
    reg_wr(1'b0, 3'h3, 32'h13572468, ok);
    chk("areg", peek, 32'h89abcdef);
    peek_idx = 4'h3;
    @(negedge clock);
    chk("dreg", peek, 32'h13572468);
    reg_rd(1'b1, 3'h3, 32'h89abcdef);
    core_halted = 1'b0;
    reg_wr(1'b0, 3'h3, 32'h0, be);
    send(cw(dbg_cmd_pkg::op_reg_read, 1'b1, dbg_cmd_pkg::size_long, 1'b0, 3'h3));
    chk("run cmd", resp_q, ok);
    send(16'h0000);
    chk("run wait", resp_q, nr);
    send(16'h0000);
    chk("run rd", resp_q, be);
    chk("dreg kept", peek, 32'h13572468);
    core_halted = 1'b1;
    mem_op(1'b0, dbg_cmd_pkg::size_long, 32'h12345677, 32'h0);
    send(16'h0000);
    chk("rd hi", resp_q, 17'h0a98b);
    send(16'h0000);
    chk("rd lo", resp_q, 17'h05674);
    mem_op(1'b0, dbg_cmd_pkg::size_word, 32'h0000abcd, 32'h0);
    send(16'h0000);
    chk("rd word", resp_q, 17'h0abcc);
    mem_op(1'b0, dbg_cmd_pkg::size_byte, 32'h00000011, 32'h0);
    send(16'h0000);
    chk("rd byte", {resp_q[16], resp_q[7:0]}, 32'h011);
    err = 1'b1;
    mem_op(1'b0, dbg_cmd_pkg::size_byte, 32'h00000012, 32'h0);
    send(16'h0000);
    chk("rd err", resp_q, be);
    mem_op(1'b1, dbg_cmd_pkg::size_word, 32'h00002001, 32'h00005555);
    send(16'h0000);
    chk("wr err", resp_q, be);
    err = 1'b0;
    attr = 5'h0a;
    mem_op(1'b1, dbg_cmd_pkg::size_long, 32'h00001002, 32'hdeadbeef);
    send(16'h0000);
    chk("wr ok", resp_q, ok);
    chk("wr data", wr_q.wdata, 32'hdeadbeef);
    // the close second word must be dropped, so the illegal flag comes one send later
    pulse(16'hfc00);
    repeat (2) @(negedge clock);
    pulse(16'h0000);
    repeat (9) @(negedge clock);
    chk("gap drop", resp_q, ok);
    send(16'h0000);
    chk("gap late", resp_q, il);
    stop_test();
  end
endmodule : tb
`default_nettype wire
